// File: eil_pkg.sv
// Shared types and constants for the external interrupt latch
package eil_pkg;

  // ****************************************************************
  // Trigger modes and reset values
  // ****************************************************************
  localparam logic MODE_EDGE = 1'b0;      // Falling edge only
  localparam logic MODE_EDGE_LEVEL = 1'b1;  // Falling edge and low level
  localparam logic PIN_IDLE = 1'b1;       // Pin rests high
  localparam logic MODE_RESET = MODE_EDGE;
  localparam logic MASK_RESET = 1'b0;
  localparam int SYNC_STAGES = 3;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  // Status and control write, one strobe carries all three bits
  typedef struct packed {
    logic ack;    // Acknowledge, write one to clear the latch
    logic mode;   // Trigger mode select
    logic mask;   // Mask, blocks the request when set
  } eil_ctl_s;

  // Whole state of the block
  typedef struct packed {
    logic [SYNC_STAGES-1:0] sync;  // Pin synchroniser, bit 0 first
    logic lvl;      // Filtered pin level
    logic latch;    // Interrupt request latch
    logic acked;    // Acknowledge seen while pin held low
    logic mode;
    logic mask;
    logic req;      // Request to the priority logic
    logic ack_pls;  // Acknowledge pulse
  } eil_state_s;

  localparam eil_state_s STATE_RESET = '{
    sync: {SYNC_STAGES{PIN_IDLE}},
    lvl: PIN_IDLE,
    latch: 1'b0,
    acked: 1'b0,
    mode: MODE_RESET,
    mask: MASK_RESET,
    req: 1'b0,
    ack_pls: 1'b0
  };

endpackage : eil_pkg

// File: eil_top.sv
// External interrupt pin latch with edge or edge-and-level triggering
module eil_top (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  // External interrupt pin, active low
  input wire logic ext_irq_pin_n_in,
  // CPU vector fetch for this interrupt
  input wire logic vec_fetch_in,
  // Status and control write
  input wire logic ctl_wr_in,
  input wire eil_pkg::eil_ctl_s ctl_wdata_in,
  // Request and status
  output logic irq_req_out,
  output logic irq_pending_out,
  output logic irq_trigger_mode_bit_out,
  output logic irq_mask_bit_out,
  output logic irq_ack_pulse_out
);

  // ****************************************************************
  // State
  // ****************************************************************
  eil_pkg::eil_state_s st_ff;
  eil_pkg::eil_state_s nxt_st;

  // Decoded events of this cycle
  logic pin_agree;
  logic pin_fall;
  logic pin_low;
  logic sw_ack;
  logic ack_now;
  logic release_ok;

  // The logic compares bits 1 and 2, the last two stages, so the depth is fixed
  if (eil_pkg::SYNC_STAGES != 3) begin : g_sync_depth_check
    $error("pin synchroniser needs exactly three stages");
  end

  // ****************************************************************
  // Events
  // ****************************************************************
  // Only the last two stages are compared, the first stays private
  assign pin_agree = st_ff.sync[1] == st_ff.sync[2];
  // Falling edge: settled level was high, new agreed sample is low
  assign pin_fall = st_ff.lvl & pin_agree & ~st_ff.sync[2];
  assign pin_low = ~st_ff.lvl;
  assign sw_ack = ctl_wr_in & ctl_wdata_in.ack;
  assign ack_now = vec_fetch_in | sw_ack;
  // Level mode releases only once acknowledged and the pin is high
  assign release_ok = (st_ff.acked | ack_now) & ~pin_low;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    nxt_st = st_ff;
    // Three-stage synchroniser, the pin is asynchronous
    nxt_st.sync = {st_ff.sync[1:0], ext_irq_pin_n_in};
    if (pin_agree) begin
      nxt_st.lvl = st_ff.sync[2];
    end
    // Control bits follow a write
    if (ctl_wr_in) begin
      nxt_st.mode = ctl_wdata_in.mode;
      nxt_st.mask = ctl_wdata_in.mask;
    end
    nxt_st.ack_pls = ack_now;
    // Set wins over any clear except reset in the same cycle
    if (st_ff.mode == eil_pkg::MODE_EDGE) begin
      nxt_st.latch = pin_fall | (st_ff.latch & ~ack_now);
      nxt_st.acked = 1'b0;
    end else begin
      // Low level keeps the latch set whatever acknowledge arrives
      nxt_st.latch = pin_fall | pin_low |
                     (st_ff.latch & ~release_ok);
      nxt_st.acked = nxt_st.latch & ~pin_fall &
                     (st_ff.acked | ack_now);
    end
    // Request follows the latch unless masked
    nxt_st.req = nxt_st.latch & ~nxt_st.mask;
    // Reset also returns to edge mode, so a held-low pin is dropped.
    // Synchroniser and filtered level keep tracking the pin, so a pin
    // held low through reset is not taken as a fresh edge afterwards.
    if (sys_rst_in) begin
      nxt_st = eil_pkg::STATE_RESET;
      nxt_st.sync = {st_ff.sync[1:0], ext_irq_pin_n_in};
      if (pin_agree) begin
        nxt_st.lvl = st_ff.sync[2];
      end
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  // One register stage; reset is folded into the next-state logic
  always_ff @(posedge core_clk_in) begin
    st_ff <= nxt_st;
  end

  // Outputs straight from the state flops
  assign irq_req_out = st_ff.req;
  assign irq_pending_out = st_ff.latch;
  assign irq_trigger_mode_bit_out = st_ff.mode;
  assign irq_mask_bit_out = st_ff.mask;
  assign irq_ack_pulse_out = st_ff.ack_pls;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (sys_rst_in);

  // Acknowledge arrives while the pin is still held low in level mode
  sequence s_ack_while_low;
    st_ff.mode && st_ff.latch && ack_now && pin_low && !ctl_wr_in;
  endsequence

  // Then the pin returns high with no new edge or write
  sequence s_pin_back_high;
    st_ff.acked && !pin_low && !pin_fall && !ctl_wr_in;
  endsequence

  a_fall_sets_latch: assert property (
    pin_fall |=> st_ff.latch)
    else $error("falling edge did not set the latch");

  a_fetch_clears: assert property (
    st_ff.mode == eil_pkg::MODE_EDGE && vec_fetch_in && !pin_fall
    && !ctl_wr_in |=> !st_ff.latch && st_ff.ack_pls)
    else $error("vector fetch did not clear the latch");

  a_sw_ack_clears: assert property (
    st_ff.mode == eil_pkg::MODE_EDGE && sw_ack && !ctl_wdata_in.mode
    && !pin_fall |=> !st_ff.latch)
    else $error("software acknowledge did not clear the latch");

  a_reset_clears: assert property (
    @(posedge core_clk_in) disable iff (1'b0)
    sys_rst_in |=> !st_ff.latch && !st_ff.req)
    else $error("reset left the latch set");

  a_reset_mode: assert property (
    @(posedge core_clk_in) disable iff (1'b0)
    sys_rst_in |=> st_ff.mode == eil_pkg::MODE_EDGE)
    else $error("reset did not return to edge mode");

  a_mode_written: assert property (
    ctl_wr_in |=> st_ff.mode == $past(ctl_wdata_in.mode))
    else $error("mode bit did not take the written value");

  a_edge_holds: assert property (
    st_ff.mode == eil_pkg::MODE_EDGE && st_ff.latch && !ack_now
    |=> st_ff.latch)
    else $error("edge mode request dropped without acknowledge");

  a_level_holds: assert property (
    st_ff.mode && pin_low && !ctl_wr_in |=> st_ff.latch)
    else $error("level mode request dropped while pin low");

  a_ack_then_high: assert property (
    s_ack_while_low |=> st_ff.acked && st_ff.latch)
    else $error("acknowledge while low was lost");

  a_release_high: assert property (
    s_pin_back_high |=> !st_ff.latch)
    else $error("level mode request not released");

  a_mask_gates: assert property (
    ##1 st_ff.req == (st_ff.latch && !st_ff.mask))
    else $error("request does not follow latch and mask");

  a_edge_from_sync: assert property (
    $rose(st_ff.latch) && $past(st_ff.mode) == eil_pkg::MODE_EDGE
    |-> $past(st_ff.lvl) && !$past(st_ff.sync[2]))
    else $error("latch set without a sampled falling edge");

  // ****************************************************************
  // Further checks on pulses, mask, mode and synchroniser
  // ****************************************************************
  // Level mode with the pin still low and no write in between
  sequence s_level_pending;
    st_ff.mode && st_ff.latch && pin_low && !ctl_wr_in;
  endsequence

  // Vector fetch makes the acknowledge pulse
  a_fetch_pulse: assert property (
    vec_fetch_in |=> st_ff.ack_pls)
    else $error("vector fetch gave no acknowledge pulse");

  // Software acknowledge makes the same pulse
  a_sw_ack_pulse: assert property (
    sw_ack |=> st_ff.ack_pls)
    else $error("software acknowledge gave no pulse");

  // Pulse lasts as many cycles as its cause, never without a cause
  a_pulse_idle: assert property (
    !ack_now |=> !st_ff.ack_pls)
    else $error("acknowledge pulse without a cause");

  // A falling edge beats an acknowledge in the same cycle
  a_set_wins: assert property (
    pin_fall && ack_now |=> st_ff.latch)
    else $error("acknowledge beat a falling edge");

  // Mask bit takes the written value
  a_mask_written: assert property (
    ctl_wr_in |=> st_ff.mask == $past(ctl_wdata_in.mask))
    else $error("mask bit did not take the written value");

  // Mode and mask only move on a write or a reset
  a_ctl_holds: assert property (
    !ctl_wr_in |=> $stable(st_ff.mode) && $stable(st_ff.mask))
    else $error("control bits moved without a write");

  // Masked request never reaches the priority logic
  a_masked_quiet: assert property (
    st_ff.mask |-> !st_ff.req)
    else $error("masked request was presented");

  // Unmasked latch is always presented
  a_unmasked_shows: assert property (
    !st_ff.mask && st_ff.latch |-> st_ff.req)
    else $error("unmasked latch not presented");

  // No request without the latch behind it
  a_req_needs_latch: assert property (
    st_ff.req |-> st_ff.latch)
    else $error("request without a latched interrupt");

  // Edge mode ignores a low level on its own
  a_edge_no_level: assert property (
    st_ff.mode == eil_pkg::MODE_EDGE && !st_ff.latch && !pin_fall
    |=> !st_ff.latch)
    else $error("edge mode latched without a falling edge");

  // Level mode: acknowledge while the pin is low leaves it pending
  a_level_low_ack: assert property (
    st_ff.mode == eil_pkg::MODE_EDGE_LEVEL && pin_low && ack_now
    |=> st_ff.latch)
    else $error("acknowledge cleared a held-low request");

  // Level mode: a held-low request persists, mode unchanged
  a_level_pending: assert property (
    s_level_pending |=> st_ff.latch && st_ff.mode)
    else $error("held-low level request was lost");

  // Level mode: no release without an acknowledge
  a_release_needs_ack: assert property (
    st_ff.mode == eil_pkg::MODE_EDGE_LEVEL && st_ff.latch
    && !st_ff.acked && !ack_now |=> st_ff.latch)
    else $error("level request released without acknowledge");

  // Release also forgets the remembered acknowledge
  a_acked_cleared: assert property (
    s_pin_back_high |=> !st_ff.acked)
    else $error("acknowledge memory kept after release");

  // Edge mode: any acknowledge clears unless an edge arrives
  a_edge_ack_clears: assert property (
    st_ff.mode == eil_pkg::MODE_EDGE && ack_now && !pin_fall
    |=> !st_ff.latch)
    else $error("edge mode acknowledge did not clear");

  // Edge mode keeps no acknowledge memory
  a_edge_no_acked: assert property (
    st_ff.mode == eil_pkg::MODE_EDGE |=> !st_ff.acked)
    else $error("edge mode kept acknowledge memory");

  // Filtered level follows once the last two stages agree
  a_lvl_follows: assert property (
    pin_agree |=> st_ff.lvl == $past(st_ff.sync[2]))
    else $error("filtered level missed an agreed sample");

  // Filtered level holds while the stages disagree
  a_lvl_waits: assert property (
    !pin_agree |=> $stable(st_ff.lvl))
    else $error("filtered level moved on a disagreement");

  // Synchroniser shifts one stage per clock
  a_sync_shift: assert property (
    1'b1 |=> st_ff.sync[1] == $past(st_ff.sync[0]))
    else $error("synchroniser did not shift");

  // Reset also clears the mask and the pulse
  a_reset_mask: assert property (
    @(posedge core_clk_in) disable iff (1'b0)
    sys_rst_in |=> !st_ff.mask && !st_ff.ack_pls)
    else $error("reset left mask or pulse set");

endmodule : eil_top

// File: eil_src_model.sv
// Model of the outside source that pulls the interrupt pin low
module eil_src_model (
  // Command from the bench
  input wire logic low_req_in,
  // Open-drain pin, pulled up when released
  output logic pin_n_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // Released pin floats up to the pull-up level, never holds a stale low
  assign pin_n_out = low_req_in ? 1'b0 : 1'b1;
endmodule : eil_src_model

// File: tb_top.sv
// Self-checking testbench for the external interrupt latch
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************************************
  // Stimulus and observed signals
  // ****************************************************************
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic src_low = 1'b0;
  logic pin_n;
  logic vf = 1'b0;
  logic wr = 1'b0;
  eil_pkg::eil_ctl_s wd = '0;
  logic req, pend, mode_q, mask_q, ackp;
  int n_mismatch = 0;
  int compares = 0;
  int cycles = 0;
  // Free-running 125 MHz clock
  always #4 clk = ~clk;
  eil_src_model eil_src_model_inst (.low_req_in(src_low), .pin_n_out(pin_n));
  eil_top eil_top_inst (.core_clk_in(clk), .sys_rst_in(rst),
    .ext_irq_pin_n_in(pin_n), .vec_fetch_in(vf), .ctl_wr_in(wr),
    .ctl_wdata_in(wd), .irq_req_out(req), .irq_pending_out(pend),
    .irq_trigger_mode_bit_out(mode_q), .irq_mask_bit_out(mask_q),
    .irq_ack_pulse_out(ackp));
  // ****************************************************************
  // Shared tasks; all stimulus moves on the falling edge
  // ****************************************************************
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  task automatic check(input logic seen, input logic exp, input string what);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %s", $time, what);
    end
  endtask : check
  task automatic give_verdict();
    $display("mismatches %0d, compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : give_verdict
  // Pin goes low; synchroniser makes the latch appear four edges later
  task automatic pin_fall();
    src_low = 1'b1;
    cyc(3);
    check(pend, 1'b0, "pending early");
    cyc(1);
    check(pend, 1'b1, "pending not set");
  endtask : pin_fall
  task automatic ctl_write(input logic a, input logic m, input logic k);
    wr = 1'b1;
    wd = '{ack: a, mode: m, mask: k};
    cyc(1);
    wr = 1'b0;
    wd = '0;
  endtask : ctl_write
  task automatic fetch();
    vf = 1'b1;
    cyc(1);
    vf = 1'b0;
  endtask : fetch
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic test_edge();
    pin_fall();
    check(req, 1'b1, "req not up");
    ctl_write(1'b1, 1'b0, 1'b0);
    check(pend, 1'b0, "ack did not clear");
    check(ackp, 1'b1, "no ack pulse");
    cyc(3);
    check(ackp, 1'b0, "ack pulse long");
    check(pend, 1'b0, "low level re-set in edge mode");
    src_low = 1'b0;
    cyc(4);
    pin_fall();
    src_low = 1'b0;
    cyc(6);
    check(pend, 1'b1, "edge latch dropped");
    fetch();
    check(pend, 1'b0, "fetch did not clear");
    check(ackp, 1'b1, "no fetch pulse");
  endtask : test_edge
  task automatic test_level();
    ctl_write(1'b0, 1'b1, 1'b0);
    check(mode_q, 1'b1, "mode not stored");
    pin_fall();
    fetch();
    cyc(3);
    check(pend, 1'b1, "cleared while pin low");
    src_low = 1'b0;
    cyc(6);
    check(pend, 1'b0, "not released on pin high");
    pin_fall();
    src_low = 1'b0;
    cyc(6);
    check(pend, 1'b1, "released without ack");
    ctl_write(1'b1, 1'b1, 1'b0);
    check(pend, 1'b0, "late ack did not clear");
  endtask : test_level
  task automatic test_mask();
    ctl_write(1'b0, 1'b0, 1'b1);
    check(mask_q, 1'b1, "mask not stored");
    pin_fall();
    check(req, 1'b0, "masked req shown");
    src_low = 1'b0;
    ctl_write(1'b0, 1'b0, 1'b0);
    cyc(1);
    check(req, 1'b1, "unmasked req hidden");
    ctl_write(1'b1, 1'b0, 1'b0);
  endtask : test_mask
  task automatic test_reset();
    cyc(3);
    ctl_write(1'b0, 1'b1, 1'b0);
    pin_fall();
    rst = 1'b1;
    cyc(6);
    rst = 1'b0;
    check(pend, 1'b0, "reset kept latch");
    check(mode_q, 1'b0, "reset kept mode");
    check(req, 1'b0, "reset kept req");
    cyc(6);
    check(pend, 1'b0, "held-low pin relatched after reset");
    check(req, 1'b0, "held-low pin raised req after reset");
    src_low = 1'b0;
  endtask : test_reset
  // Hang guard: the whole run needs well under this many cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  // Main sequence
  initial begin
    cyc(6);
    rst = 1'b0;
    test_edge();
    test_level();
    test_mask();
    test_reset();
    give_verdict();
  end
endmodule : tb_top
